// file: src/dac_range_pkg.sv
// package: register map, range codes and carriers for the dac group range/clamp control
package dac_range_pkg;
    // register offsets
    localparam logic [7:0] DEV_CONFIG_ADDR = 8'h02;
    localparam logic [7:0] RANGE_LO_ADDR = 8'h1e;
    localparam logic [7:0] RANGE_HI_ADDR = 8'h1f;
    localparam logic [7:0] DATA_FIRST_ADDR = 8'h50;
    localparam logic [7:0] DATA_LAST_ADDR = 8'h6f;
    localparam logic [7:0] GEN_STATUS_ADDR = 8'h72;
    localparam logic [7:0] PDN_LO_ADDR = 8'hb2;
    localparam logic [7:0] PDN_HI_ADDR = 8'hb3;
    // geometry
    localparam int NUM_GROUPS = 4;
    localparam int CH_PER_GROUP = 4;
    localparam int NUM_CH = 16;
    localparam int CODE_W = 12;
    // reset values
    localparam logic [7:0] DEV_CONFIG_RST = 8'h00;
    localparam logic [7:0] PDN_RST = 8'h00;
    localparam logic [11:0] DATA_RST = 12'h000;
    // range codes, two bits per group; lo register holds groups a,b; hi holds c,d
    typedef enum logic [1:0] {
        RANGE_NEG10 = 2'b00,
        RANGE_NEG5 = 2'b01,
        RANGE_POS5 = 2'b10,
        RANGE_POS10 = 2'b11
    } range_e;
    // register port request
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [15:0] wdata;
    } reg_req_s;
    // per-group analog control
    typedef struct packed {
        logic clamp;
        range_e range;
    } group_ctl_s;
endpackage

// file: src/dac_group_range_clamp_ctrl.sv
// dac group range and clamp control with auto-range detection
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------
// ----------------------------------------------------------------
module dac_group_range_clamp_ctrl
    import dac_range_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // register port
    input wire reg_req_s req_in,
    output logic [15:0] rdata_out,
    output logic rvalid_out,
    // comparator results, high when group sense is below threshold
    input wire logic [NUM_GROUPS-1:0] sense_below_in,
    // analog side
    output group_ctl_s [NUM_GROUPS-1:0] group_ctl_out,
    output logic [NUM_CH*CODE_W-1:0] tap_sel_out
);
    // ----------------------------------------------------------------
    // register state
    // ----------------------------------------------------------------
    logic [7:0] config_r, config_nxt;
    logic [15:0] pdn_r, pdn_nxt;
    logic [NUM_GROUPS-1:0] detect_r, detect_nxt;
    range_e [NUM_GROUPS-1:0] range_r, range_nxt;
    logic [NUM_GROUPS-1:0] clamp_r, clamp_nxt;
    logic [CODE_W-1:0] data_r [NUM_CH];
    logic [CODE_W-1:0] data_nxt [NUM_CH];
    logic trigger_r, trigger_nxt;
    logic [15:0] rdata_nxt;
    logic rvalid_nxt;
    logic detect_wr;
    logic [4:0] data_idx;

    assign data_idx = 5'(req_in.addr - DATA_FIRST_ADDR);
    assign detect_wr = req_in.wr && (req_in.addr == PDN_LO_ADDR
        || req_in.addr == PDN_HI_ADDR || req_in.addr == DEV_CONFIG_ADDR);

    // ----------------------------------------------------------------
    // next-state logic
    // ----------------------------------------------------------------
    // a write in the detection cycle wins, so software keeps the last word
    always_comb begin
        config_nxt = config_r;
        pdn_nxt = pdn_r;
        range_nxt = range_r;
        clamp_nxt = clamp_r;
        detect_nxt = detect_r;
        trigger_nxt = detect_wr;
        data_nxt = data_r;
        // detection one cycle after the trigger, comparators sampled once
        if (trigger_r) begin
            detect_nxt = sense_below_in;
            for (int g = 0; g < NUM_GROUPS; g++) begin
                if (sense_below_in[g]) begin
                    range_nxt[g] = RANGE_NEG10;
                end else begin
                    range_nxt[g] = RANGE_POS5;
                end
                clamp_nxt[g] = 1'b0; // leave clamp once range known
            end
        end
        if (req_in.wr) begin
            case (req_in.addr)
                DEV_CONFIG_ADDR: config_nxt = req_in.wdata[7:0];
                PDN_LO_ADDR: pdn_nxt[7:0] = req_in.wdata[7:0];
                PDN_HI_ADDR: pdn_nxt[15:8] = req_in.wdata[7:0];
                // any code accepted, also positive with negative clamp
                RANGE_LO_ADDR: begin
                    range_nxt[0] = range_e'(req_in.wdata[1:0]);
                    range_nxt[1] = range_e'(req_in.wdata[3:2]);
                end
                RANGE_HI_ADDR: begin
                    range_nxt[2] = range_e'(req_in.wdata[1:0]);
                    range_nxt[3] = range_e'(req_in.wdata[3:2]);
                end
                default: begin
                    if (req_in.addr >= DATA_FIRST_ADDR && req_in.addr <= DATA_LAST_ADDR
                        && !req_in.addr[0]) begin
                        data_nxt[data_idx[4:1]] = req_in.wdata[CODE_W-1:0];
                    end
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // read path
    // ----------------------------------------------------------------
    always_comb begin
        rvalid_nxt = req_in.rd;
        rdata_nxt = 16'h0000;
        if (req_in.rd) begin
            case (req_in.addr)
                DEV_CONFIG_ADDR: rdata_nxt = {8'h00, config_r};
                PDN_LO_ADDR: rdata_nxt = {8'h00, pdn_r[7:0]};
                PDN_HI_ADDR: rdata_nxt = {8'h00, pdn_r[15:8]};
                RANGE_LO_ADDR: rdata_nxt = {12'h000, range_r[1], range_r[0]};
                RANGE_HI_ADDR: rdata_nxt = {12'h000, range_r[3], range_r[2]};
                GEN_STATUS_ADDR: rdata_nxt = {12'h000, detect_r};
                default: begin
                    if (req_in.addr >= DATA_FIRST_ADDR && req_in.addr <= DATA_LAST_ADDR
                        && !req_in.addr[0]) begin
                        rdata_nxt = {4'h0, data_r[data_idx[4:1]]};
                    end
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // state registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            config_r <= DEV_CONFIG_RST;
            pdn_r <= {PDN_RST, PDN_RST};
            detect_r <= '0;
            range_r <= '{default: RANGE_POS5};
            clamp_r <= '1;
            trigger_r <= 1'b1;
            rdata_out <= 16'h0000;
            rvalid_out <= 1'b0;
            for (int c = 0; c < NUM_CH; c++) begin
                data_r[c] <= DATA_RST;
            end
        end else begin
            config_r <= config_nxt;
            pdn_r <= pdn_nxt;
            detect_r <= detect_nxt;
            range_r <= range_nxt;
            clamp_r <= clamp_nxt;
            trigger_r <= trigger_nxt;
            rdata_out <= rdata_nxt;
            rvalid_out <= rvalid_nxt;
            data_r <= data_nxt;
        end
    end

    // ----------------------------------------------------------------
    // analog outputs
    // ----------------------------------------------------------------
    // clamp comes only from reset (set) and detection (cleared), so range is not an input here
    genvar gi;
    generate
        for (gi = 0; gi < NUM_CH; gi++) begin : g_ch
            // tap index equals code: larger code never picks a lower node
            assign tap_sel_out[gi*CODE_W +: CODE_W] = data_r[gi];
        end
        for (gi = 0; gi < NUM_GROUPS; gi++) begin : g_grp
            assign group_ctl_out[gi].clamp = clamp_r[gi];
            assign group_ctl_out[gi].range = range_r[gi];
        end
    endgenerate

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    sequence detect_trig_s;
        detect_wr;
    endsequence

    detect_rerun_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        detect_trig_s |=> ##1 (detect_r == $past(sense_below_in)))
        else $error("detection not rerun after trigger write");
    range_low_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        trigger_r && sense_below_in[0] && !(req_in.wr && req_in.addr == RANGE_LO_ADDR)
        |=> range_r[0] == RANGE_NEG10)
        else $error("group a not set to -10 range");
    range_high_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        trigger_r && !sense_below_in[3] && !(req_in.wr && req_in.addr == RANGE_HI_ADDR)
        |=> range_r[3] == RANGE_POS5)
        else $error("group d not set to 0..5 range");
    status_hold_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        !trigger_r |=> $stable(detect_r))
        else $error("status changed without trigger");
    status_read_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        req_in.rd && req_in.addr == GEN_STATUS_ADDR |=> rvalid_out
        && rdata_out == {12'h000, $past(detect_r)})
        else $error("status read wrong");
    range_write_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        req_in.wr && req_in.addr == RANGE_HI_ADDR |=> range_r[2] == $past(req_in.wdata[1:0]))
        else $error("range write not applied");
    clamp_release_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        trigger_r |=> clamp_r == '0)
        else $error("clamp not released after detection");
    tap_code_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        req_in.wr && req_in.addr == DATA_FIRST_ADDR
        |=> tap_sel_out[CODE_W-1:0] == $past(req_in.wdata[CODE_W-1:0]))
        else $error("tap select not following code");

    sequence odd_data_wr_s;
        req_in.wr && req_in.addr[0]
            && req_in.addr >= DATA_FIRST_ADDR && req_in.addr <= DATA_LAST_ADDR;
    endsequence

    // odd halves of a data word are dropped, taps must not move
    data_odd_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        odd_data_wr_s |=> $stable(tap_sel_out))
        else $error("odd data address changed a tap");
    range_lo_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        req_in.wr && req_in.addr == RANGE_LO_ADDR |=> range_r[0] == $past(req_in.wdata[1:0])
        && range_r[1] == $past(req_in.wdata[3:2]))
        else $error("low range write not applied");
    read_idle_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        !req_in.rd |=> !rvalid_out)
        else $error("read valid without read");
endmodule
`default_nettype wire

// file: test/tb.sv
// self-checking bench for the dac group range and clamp control
`timescale 1ns/10ps
`default_nettype none
module tb;
    import dac_range_pkg::*;
    logic clk_in;
    logic rst_n_in;
    reg_req_s req;
    logic [3:0] sense;
    logic [3:0] held;
    logic [15:0] rdata;
    logic rvalid;
    group_ctl_s [NUM_GROUPS-1:0] ctl;
    logic [NUM_CH*CODE_W-1:0] taps;
    int fail_count;
    int compares;
    logic [31:0] seed;
    logic [15:0] rd_v;
    logic [15:0] rng;
    logic [11:0] code;
    logic [7:0] trig [3] = '{DEV_CONFIG_ADDR, PDN_LO_ADDR, PDN_HI_ADDR};

    dac_group_range_clamp_ctrl uut (.clk_in(clk_in), .rst_n_in(rst_n_in), .req_in(req),
        .rdata_out(rdata), .rvalid_out(rvalid), .sense_below_in(sense),
        .group_ctl_out(ctl), .tap_sel_out(taps));

    // ------------------------------------------------
    // helpers
    // ------------------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction

    function automatic logic [1:0] det_range(input logic below);
        return below ? RANGE_NEG10 : RANGE_POS5;
    endfunction

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // one-cycle strobe, one idle cycle before the next request
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(negedge clk_in);
        req.wr = 1'b1;
        req.addr = a;
        req.wdata = d;
        @(negedge clk_in);
        req.wr = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(negedge clk_in);
        req.rd = 1'b1;
        req.addr = a;
        @(negedge clk_in);
        req.rd = 1'b0;
        chk({15'h0, rvalid}, 16'h0001);
        d = rdata;
    endtask

    task automatic chk_det(input logic [3:0] s);
        @(negedge clk_in);
        for (int g = 0; g < NUM_GROUPS; g++) begin
            chk({14'h0, ctl[g].range}, {14'h0, det_range(s[g])});
            chk({15'h0, ctl[g].clamp}, 16'h0000);
        end
        rd(GEN_STATUS_ADDR, rd_v);
        chk(rd_v, {12'h0, s});
    endtask

    task automatic end_sim;
        $display("checks %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // ------------------------------------------------
    // clock and watchdog
    // ------------------------------------------------
    initial begin
        clk_in = 1'b0;
        forever #20 clk_in = ~clk_in;
    end

    initial begin
        #(40 * 4000);
        fail_count++;
        end_sim();
    end

    // ------------------------------------------------
    // main sequence
    // ------------------------------------------------
    initial begin
        req = '0;
        sense = 4'h5;
        rst_n_in = 1'b0;
        seed = 71;
        fail_count = 0;
        compares = 0;
        for (int p = 0; p < 2; p++) begin
            repeat (20) @(negedge clk_in);
            for (int g = 0; g < NUM_GROUPS; g++) begin
                chk({15'h0, ctl[g].clamp}, 16'h0001);
            end
            chk({15'h0, taps == '0}, 16'h0001);
            rst_n_in = 1'b1;
            chk_det(sense);
            rd(DATA_FIRST_ADDR, rd_v);
            chk(rd_v, 16'h0000);
            // detection rerun from each trigger register, result held between triggers
            for (int i = 0; i < 9; i++) begin
                seed = xs(seed);
                sense = seed[3:0];
                wr(trig[i % 3], seed[23:8]);
                @(posedge clk_in);
                chk_det(sense);
                rd(trig[i % 3], rd_v);
                chk(rd_v, {8'h0, seed[15:8]});
                held = sense;
                sense = ~sense;
                repeat (3) @(negedge clk_in);
                chk_det(held);
            end
            // each code once across groups a..d, then five random sets, positive range with sense below allowed
            for (int i = 0; i < 6; i++) begin
                seed = xs(seed);
                rng = (i == 0) ? 16'h1be4 : seed[15:0];
                wr(RANGE_LO_ADDR, {12'h0, rng[3:0]});
                wr(RANGE_HI_ADDR, {12'h0, rng[7:4]});
                for (int g = 0; g < NUM_GROUPS; g++) begin
                    chk({14'h0, ctl[g].range}, {14'h0, rng[g*2+:2]});
                    chk({15'h0, ctl[g].clamp}, 16'h0000);
                end
                rd(RANGE_LO_ADDR, rd_v);
                chk(rd_v, {12'h0, rng[3:0]});
                rd(RANGE_HI_ADDR, rd_v);
                chk(rd_v, {12'h0, rng[7:4]});
            end
            for (int n = 0; n < NUM_CH; n++) begin
                seed = xs(seed);
                code = (n == 0) ? 12'hfff : seed[11:0];
                wr(DATA_FIRST_ADDR + 8'(2 * n), {4'h0, code});
                wr(DATA_FIRST_ADDR + 8'(2 * n + 1), 16'h0000);
                chk({4'h0, taps[n*CODE_W+:CODE_W]}, {4'h0, code});
                rd(DATA_FIRST_ADDR + 8'(2 * n), rd_v);
                chk({4'h0, rd_v[11:0]}, {4'h0, code});
            end
            rd(8'h70, rd_v);
            chk(rd_v, 16'h0000);
            @(negedge clk_in);
            rst_n_in = 1'b0;
        end
        end_sim();
    end
endmodule
`default_nettype wire
